/* rtl/async_rx_clock_data_recovery.sv */
// Asynchronous receive clock recovery and majority-vote data recovery.
// Assumes a remote transmitter on rxLine and a consumer that takes frameValid.
//
// Behaviour
// - Sample the line at 16x baud normally, 8x baud in double speed.
// - Double speed oversampling applies when doubleSpeedSelect is one.
// - Start qualification begins on idle-high to low; first low sample is one.
// - Start judged on samples 8,9,10 normal, or 4,5,6 double speed.
// - Two or more high start samples reject start; search for next edge.
// - Bit timing is resynchronised on every accepted start bit.
// - Recovery steps 16 states per bit normal, 8 in double speed.
// - Each bit decided by majority of its three centre samples.
// - Capture through first stop bit; further stop bits are ignored.
// - Voted first stop bit of zero sets the frame error flag.
// - Ready for next start edge right after last stop voting sample.
// - Character plus parity length from five to ten bits is supported.
// - Frame error travels with its own frame to the buffer.
// - Clearing receiverEnableBit stops recovery at once, abandoning the frame.
`timescale 1ns/1ps
`default_nettype none

module async_rx_clock_data_recovery
  import rx_recovery_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic rxLine,
  input wire logic receiverEnableBit,
  input wire logic doubleSpeedSelect,
  input wire logic [3:0] frameBits,
  input wire logic [15:0] sampleDivisor,
  output logic frameValid,
  output logic [9:0] frameData,
  output logic frameErrorFlag
);

  function automatic logic vote3(input logic [2:0] s);
    vote3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  // Synchroniser; first stage feeds only the second
  // Third flop holds the sample that the edge detector and the votes use
  logic syncA_q, syncB_q, lineSeen_q;
  logic syncA_d, syncB_d, lineSeen_d;

  always_comb begin
    syncA_d = rxLine;
    syncB_d = syncA_q;
    lineSeen_d = syncB_q;
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      syncA_q <= 1'b1;
      syncB_q <= 1'b1;
      lineSeen_q <= 1'b1;
    end else begin
      syncA_q <= syncA_d;
      syncB_q <= syncB_d;
      lineSeen_q <= lineSeen_d;
    end
  end

  // Sample tick divider: one-cycle pulse every sampleDivisor+1 clocks
  // Reloads while disabled, so the first tick after enable is a full period late
  logic [15:0] divCnt_q, divCnt_d;
  logic tick_q, tick_d;

  always_comb begin
    tick_d = 1'b0;
    divCnt_d = divCnt_q - 16'h0001;
    if (!receiverEnableBit) begin
      divCnt_d = sampleDivisor;
    end else if (divCnt_q == 16'h0000) begin
      divCnt_d = sampleDivisor;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      divCnt_q <= TICK_DIV_RESET;
      tick_q <= 1'b0;
    end else begin
      divCnt_q <= divCnt_d;
      tick_q <= tick_d;
    end
  end

  // Recovery state machine
  rx_state_e state_q, state_d;
  logic [3:0] phase_q, phase_d;
  logic [3:0] bitIdx_q, bitIdx_d;
  logic [2:0] votes_q, votes_d;
  logic [9:0] shift_q, shift_d;
  logic prevLine_q, prevLine_d;
  logic frameValid_d, frameErrorFlag_d;
  logic [9:0] frameData_d;
  logic [3:0] lastPhase, voteFirst, bitCount;
  logic voteNow, voteDone, voted;

  always_comb begin
    lastPhase = doubleSpeedSelect ? SAMPLES_DOUBLE_LAST : SAMPLES_NORMAL_LAST;
    voteFirst = doubleSpeedSelect ? VOTE_FIRST_DOUBLE : VOTE_FIRST_NORMAL;
    // Out-of-range lengths are clamped, not refused
    if (frameBits < DATA_BITS_MIN) begin
      bitCount = DATA_BITS_MIN;
    end else if (frameBits > DATA_BITS_MAX) begin
      bitCount = DATA_BITS_MAX;
    end else begin
      bitCount = frameBits;
    end
    // phase holds sample number-1; samples F, F+1, F+2 are voted
    voteNow = (phase_q >= voteFirst - 4'h1) && (phase_q <= voteFirst + 4'h1);
    voteDone = (phase_q == voteFirst + 4'h1);
    // Only meaningful at voteDone, once all three centre samples are in
    voted = vote3({votes_q[1:0], lineSeen_q});
  end

  always_comb begin
    state_d = state_q;
    phase_d = phase_q;
    bitIdx_d = bitIdx_q;
    votes_d = votes_q;
    shift_d = shift_q;
    prevLine_d = prevLine_q;
    frameValid_d = 1'b0;
    frameData_d = frameData;
    frameErrorFlag_d = frameErrorFlag;
    if (!receiverEnableBit) begin
      // Drop the frame at once; counters restart clean on the next enable
      state_d = RX_IDLE;
      prevLine_d = 1'b1;
      phase_d = 4'h0;
      bitIdx_d = 4'h0;
      votes_d = 3'h7;
      shift_d = 10'h000;
    end else if (tick_q) begin
      prevLine_d = lineSeen_q;
      if (voteNow) begin
        votes_d = {votes_q[1:0], lineSeen_q};
      end
      unique case (state_q)
        RX_IDLE: begin
          // A start needs a high sample then a low one; reset and disable set the history high, so a line low at enable starts a frame
          if (prevLine_q && !lineSeen_q) begin
            state_d = RX_START;
            phase_d = 4'h1;
          end
        end
        RX_START: begin
          phase_d = phase_q + 4'h1;
          if (voteDone) begin
            if (voted) begin
              // Edge history keeps the last sample; a new start needs high then low
              state_d = RX_IDLE;
            end
          end
          if (phase_q == lastPhase) begin
            state_d = RX_BITS;
            phase_d = 4'h0;
            bitIdx_d = 4'h0;
            shift_d = 10'h000;
          end
        end
        RX_BITS: begin
          phase_d = (phase_q == lastPhase) ? 4'h0 : phase_q + 4'h1;
          if (voteDone) begin
            shift_d[bitIdx_q] = voted;
          end
          if (phase_q == lastPhase) begin
            bitIdx_d = bitIdx_q + 4'h1;
            if (bitIdx_q == bitCount - 4'h1) begin
              state_d = RX_STOP;
            end
          end
        end
        RX_STOP: begin
          phase_d = phase_q + 4'h1;
          if (voteDone) begin
            // Edge history keeps the last stop sample, so a low stop bit
            // (a break) cannot pose as the next start edge
            state_d = RX_IDLE;
            frameValid_d = 1'b1;
            frameData_d = shift_q;
            frameErrorFlag_d = ~voted;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_q <= RX_IDLE;
      phase_q <= 4'h0;
      bitIdx_q <= 4'h0;
      votes_q <= 3'h7;
      shift_q <= 10'h000;
      prevLine_q <= 1'b1;
      frameValid <= 1'b0;
      frameData <= 10'h000;
      frameErrorFlag <= 1'b0;
    end else begin
      state_q <= state_d;
      phase_q <= phase_d;
      bitIdx_q <= bitIdx_d;
      votes_q <= votes_d;
      shift_q <= shift_d;
      prevLine_q <= prevLine_d;
      frameValid <= frameValid_d;
      frameData <= frameData_d;
      frameErrorFlag <= frameErrorFlag_d;
    end
  end

endmodule

`default_nettype wire

/* rtl/rx_recovery_pkg.sv */
// Package for the asynchronous receive clock and data recovery block.
// Assumes one system clock; sample tick is produced inside the block.
package rx_recovery_pkg;

  localparam int unsigned TICK_DIV_W = 16;
  localparam logic [3:0] SAMPLES_NORMAL_LAST = 4'hf;
  localparam logic [3:0] SAMPLES_DOUBLE_LAST = 4'h7;
  // Voting samples (1-based sample numbers); counter holds number-1
  localparam logic [3:0] VOTE_FIRST_NORMAL = 4'h8;
  localparam logic [3:0] VOTE_FIRST_DOUBLE = 4'h4;
  localparam logic [3:0] DATA_BITS_MIN = 4'h5;
  localparam logic [3:0] DATA_BITS_MAX = 4'ha;
  localparam logic [3:0] DATA_BITS_RESET = 4'h8;
  localparam logic [15:0] TICK_DIV_RESET = 16'h0000;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_BITS,
    RX_STOP
  } rx_state_e;

  typedef struct packed {
    logic [9:0] bits;
    logic frameError;
  } rx_frame_s;

endpackage

/* tb/rx_recovery_asserts.sv */
// Checker bound to the recovery block.
// Assumes one clock, sync active-low reset.
`timescale 1ns/1ps
`default_nettype none
module rx_recovery_asserts (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic rxLine,
  input wire logic receiverEnableBit,
  input wire logic frameValid,
  input wire logic frameErrorFlag,
  input wire logic [3:0] frameBits,
  input wire logic [9:0] frameData
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic [5:0] gap_q, gap_d;
  // Saturates so long idle spells stay legal
  always_comb gap_d = frameValid ? 6'h00 : gap_q + 6'(gap_q != 6'h3f);
  always_ff @(posedge core_clk) gap_q <= rstn ? gap_d : 6'h00;
  sequence lineLow; (!rxLine) [*8]; endsequence
  sequence lineHigh; rxLine [*8]; endsequence
  a_min_gap: assert property (frameValid |-> gap_q >= 6'h35) else $error("gap");
  a_pulse_once: assert property (frameValid |=> (!frameValid) [*8]) else $error("pulse");
  a_off_silent: assert property (!receiverEnableBit |=> !frameValid) else $error("off");
  a_off_abandon: assert property ($fell(receiverEnableBit) |=> (!frameValid) [*8])
    else $error("abandon");
  a_upper_zero: assert property (frameValid && frameBits inside {[4'h5:4'ha]}
    |-> (frameData >> frameBits) == 10'h000) else $error("upper");
  a_stop_low: assert property (lineLow ##1 frameValid |-> frameErrorFlag) else $error("fe");
  a_stop_high: assert property (lineHigh ##1 frameValid |-> !frameErrorFlag) else $error("ok");
  a_data_hold: assert property (!frameValid |-> $stable(frameData) && $stable(frameErrorFlag))
    else $error("hold");
endmodule
bind async_rx_clock_data_recovery rx_recovery_asserts chk (.core_clk, .rstn, .rxLine,
  .receiverEnableBit, .frameValid, .frameErrorFlag, .frameBits, .frameData);
`default_nettype wire

/* tb/serial_tx_model.sv */
// Remote serial source, line idles high.
// Assumes bit lengths in whole clocks at divisor zero.
`timescale 1ns/1ps
`default_nettype none
module serial_tx_model (
  input wire logic core_clk,
  output logic txLine
);
  initial txLine = 1'b1;
  // Exact bit lengths keep the rate error at zero
  task automatic send(input logic [11:0] f, input int nb, input int len);
    for (int i = 0; i < nb; i++) begin
      txLine <= f[i];
      repeat (len) @(posedge core_clk);
    end
  endtask
endmodule
`default_nettype wire

/* tb/testbench.sv */
// Bench: serial source, receiver, expected-frame queue.
// Assumes the checker binds itself to the receiver.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk = 1'b0, rstn = 1'b0, receiverEnableBit = 1'b0, doubleSpeedSelect = 1'b0;
  logic rxLine, frameValid, frameErrorFlag;
  logic [3:0] frameBits = 4'h8;
  logic [15:0] sampleDivisor = 16'h0000;
  logic [9:0] frameData, d;
  logic [10:0] q[$];
  int err_count = 0, cmp_count = 0;
  always #10 core_clk = ~core_clk;
  serial_tx_model tx (.core_clk, .txLine(rxLine));
  async_rx_clock_data_recovery uut (.core_clk, .rstn, .rxLine, .receiverEnableBit,
    .doubleSpeedSelect, .frameBits, .sampleDivisor, .frameValid, .frameData, .frameErrorFlag);
  task summarize;
    cmp_count++;
    if (q.size() != 0) begin
      err_count++;
      $display("[ERR] pending frames exp 0 got %0d", q.size());
    end
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Length changes only inside a start bit, never mid-data
  task automatic frame(input int n, input logic stop);
    int spb, nb, len;
    spb = (doubleSpeedSelect ? 8 : 16) * (int'(sampleDivisor) + 1);
    nb = n < 5 ? 5 : (n > 10 ? 10 : n);
    d = 10'($urandom) & ((10'h001 << nb) - 10'h001);
    q.push_back({d, ~stop});
    tx.send(12'h000, 1, spb);
    frameBits <= 4'(n);
    tx.send({2'b00, d}, nb, spb);
    len = stop ? spb - (doubleSpeedSelect ? 2 : 6) * (int'(sampleDivisor) + 1) : 20;
    tx.send({11'h000, stop}, 1, len);
    if (!stop) tx.send(12'h001, 1, 16);
  endtask
  always @(posedge core_clk) begin
    if (frameValid === 1'b1) begin
      cmp_count++;
      if (q.size() == 0 || q[0] !== {frameData, frameErrorFlag}) begin
        err_count++;
        $display("[ERR] frame exp %h got %h", q.size() ? q[0] : 11'h000,
          {frameData, frameErrorFlag});
      end
      if (q.size() > 0) void'(q.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    summarize();
  end
  initial begin
    void'($urandom(71));
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    receiverEnableBit <= 1'b1;
    repeat (8) @(posedge core_clk);
    for (int m = 0; m < 3; m++) begin
      doubleSpeedSelect <= (m == 2);
      sampleDivisor <= 16'(m == 1);
      @(posedge core_clk);
      for (int n = 5; n <= 10; n++) frame(n, n != 7);
      tx.send(12'h000, 1, m == 2 ? 4 : (m == 1 ? 16 : 8));
      tx.send(12'h001, 1, 40);
    end
    fork
      tx.send(12'h3fe, 10, 8);
      begin
        repeat (30) @(posedge core_clk);
        receiverEnableBit <= 1'b0;
        @(posedge core_clk);
        receiverEnableBit <= 1'b1;
      end
    join
    frame(3, 1'b1);
    frame(15, 1'b1);
    frame(8, 1'b1);
    repeat (60) @(posedge core_clk);
    summarize();
  end
endmodule
`default_nettype wire
